/* hdl/card_pkg.sv */
// Constants and types shared by the card host interface and its sequencer.
package card_pkg;

  // ****************************************************************
  // Clock and local memory timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int MEM_ACCESS_NS = 24;
  // Least access time rounded up to whole clock cycles.
  localparam int MEM_PHASE_CYCLES_INT =
    (MEM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] MEM_PHASE_LAST = 4'(MEM_PHASE_CYCLES_INT - 1);
  localparam logic [3:0] COUNT_ZERO     = 4'h0;
  localparam logic [3:0] COUNT_STEP     = 4'h1;

  // ****************************************************************
  // Attribute space layout
  // ****************************************************************
  localparam logic [15:0] CCR_FIRST_ADDR  = 16'h03F0;
  localparam logic [15:0] CCR_SECOND_ADDR = 16'h03F2;
  localparam logic [15:0] CCR_THIRD_ADDR  = 16'h03F4;
  localparam logic [15:0] CCR_FOURTH_ADDR = 16'h03F6;
  localparam int          CCR_COUNT       = 4;
  localparam logic [7:0]  CCR_RESET       = 8'h00;
  localparam logic [15:0] ADDR_STEP       = 16'h0001;

  // ****************************************************************
  // Card configuration register fields
  // ****************************************************************
  localparam int         CFG_INDEX_MSB  = 5;
  localparam logic [5:0] CFG_INDEX_NONE = 6'h00;
  localparam int         SOFT_RESET_BIT = 7;
  localparam int         INTR_BIT       = 1;

  // ****************************************************************
  // I/O window decode
  // ****************************************************************
  localparam int         IO_REG_BITS          = 5;
  localparam logic [4:0] SRAM_DATA_PORT_INDEX = 5'h10;

  // ****************************************************************
  // Shared ISA interrupt pins, in order 15, 12, 11, 10, 3, 4, 5, 9
  // ****************************************************************
  localparam int IRQ_PINS     = 8;
  localparam int PIN_SRAM_CS  = 1;
  localparam int PIN_INPACK   = 2;
  localparam int PIN_STSCHG   = 3;
  localparam int PIN_IREQ     = 4;

  // ****************************************************************
  // Byte pair sequencer states, Gray coded along the wide path
  // ****************************************************************
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_LOW  = 2'b01,
    SEQ_HIGH = 2'b11,
    SEQ_DONE = 2'b10
  } seq_state_type;

endpackage

/* hdl/byte_pair_sequencer.sv */
// Byte pair sequencer that runs one or two 8-bit local memory accesses.
`timescale 1ns/1ps
`default_nettype none
module byte_pair_sequencer
  import card_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic        wide,
  input  wire logic        write,
  input  wire logic [15:0] base_addr,
  input  wire logic [15:0] wdata,
  input  wire logic [7:0]  mem_rdata,
  output logic             busy,
  output logic             done,
  output logic [15:0]      rdata,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             mem_rd,
  output logic             mem_wr
);
  import card_pkg::*;

  seq_state_type state, next_state;
  logic [3:0]    count, next_count;
  logic          wide_q, next_wide_q;
  logic          write_q, next_write_q;
  logic [15:0]   addr_q, next_addr_q;
  logic [15:0]   wdata_q, next_wdata_q;
  logic [15:0]   next_rdata;

  // ****************************************************************
  // Sequencing
  // ****************************************************************

  // Steps through low byte then, when wide, high byte, one phase each.
  always_comb begin
    next_state   = state;
    next_count   = count;
    next_wide_q  = wide_q;
    next_write_q = write_q;
    next_addr_q  = addr_q;
    next_wdata_q = wdata_q;
    next_rdata   = rdata;
    case (state)
      SEQ_IDLE: begin
        if (start) begin
          next_state   = SEQ_LOW;
          next_count   = COUNT_ZERO;
          next_wide_q  = wide;
          next_write_q = write;
          next_addr_q  = base_addr;
          next_wdata_q = wdata;
        end
      end
      SEQ_LOW: begin
        if (count == MEM_PHASE_LAST) begin
          next_rdata[7:0] = mem_rdata;
          next_count      = COUNT_ZERO;
          next_state      = wide_q ? SEQ_HIGH : SEQ_DONE;
        end else begin
          next_count = count + COUNT_STEP;
        end
      end
      SEQ_HIGH: begin
        if (count == MEM_PHASE_LAST) begin
          next_rdata[15:8] = mem_rdata;
          next_state       = SEQ_DONE;
        end else begin
          next_count = count + COUNT_STEP;
        end
      end
      SEQ_DONE: begin
        next_state = SEQ_IDLE;
      end
      default: begin
        next_state = SEQ_IDLE;
      end
    endcase
  end

  // Registers the sequencer state; a low clock enable freezes it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= SEQ_IDLE;
      count   <= COUNT_ZERO;
      wide_q  <= 1'b0;
      write_q <= 1'b0;
      addr_q  <= 16'h0000;
      wdata_q <= 16'h0000;
      rdata   <= 16'h0000;
    end else if (clk_en) begin
      state   <= next_state;
      count   <= next_count;
      wide_q  <= next_wide_q;
      write_q <= next_write_q;
      addr_q  <= next_addr_q;
      wdata_q <= next_wdata_q;
      rdata   <= next_rdata;
    end
  end

  // Drives the memory strobes from the registered state.
  assign busy      = (state != SEQ_IDLE);
  assign done      = (state == SEQ_DONE);
  assign mem_addr  = (state == SEQ_HIGH) ? addr_q + ADDR_STEP : addr_q;
  assign mem_wdata = (state == SEQ_HIGH) ? wdata_q[15:8] : wdata_q[7:0];
  assign mem_rd    = (state == SEQ_LOW || state == SEQ_HIGH) && !write_q;
  assign mem_wr    = (state == SEQ_LOW || state == SEQ_HIGH) && write_q;

endmodule // byte_pair_sequencer
`default_nettype wire

/* hdl/pc_card_host_interface.sv */
// Card mode host port: strap, pin reuse, attribute decode and routing.
`timescale 1ns/1ps
`default_nettype none
module pc_card_host_interface
  import card_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  input  wire logic                card_mode_strap,
  input  wire logic                sleep_n,
  input  wire logic                ce1_n,
  input  wire logic                ce2_n,
  input  wire logic                reg_n,
  input  wire logic                we_n,
  input  wire logic                oe_n,
  input  wire logic                iord_n,
  input  wire logic                iowr_n,
  input  wire logic                boot_rom_pin_n,
  input  wire logic [15:0]         addr,
  input  wire logic [15:0]         data_in,
  input  wire logic                shared_memory_match,
  input  wire logic                pio_select,
  input  wire logic                nonvolatile_write_enable,
  input  wire logic                core_irq,
  input  wire logic [15:0]         core_rdata,
  input  wire logic [15:0]         sram_pointer,
  input  wire logic                isa_channel_ready,
  input  wire logic                isa_io_width16,
  input  wire logic [IRQ_PINS-1:0] isa_irq_drive,
  input  wire logic [7:0]          mem_rdata,
  output logic [15:0]              data_out,
  output logic                     data_oe,
  output logic                     ready_pin_out,
  output logic                     ready_pin_oe,
  output logic                     width_pin_out,
  output logic                     width_pin_oe,
  output logic [IRQ_PINS-1:0]      irq_pin_out,
  output logic [IRQ_PINS-1:0]      irq_pin_oe,
  output logic                     card_mode,
  output logic                     core_sleep_n,
  output logic                     eeprom_optional,
  output logic                     core_soft_reset,
  output logic [IO_REG_BITS-1:0]   core_reg_index,
  output logic                     core_io_rd,
  output logic                     core_io_wr,
  output logic [15:0]              core_wdata,
  output logic                     byte_high_enable_n,
  output logic                     address_enable_isa,
  output logic                     isa_memr_n,
  output logic                     isa_memw_n,
  output logic                     isa_ior_n,
  output logic                     isa_iow_n,
  output logic                     boot_rom_match_n,
  output logic [15:0]              mem_addr,
  output logic [7:0]               mem_wdata,
  output logic                     flash_cs_n,
  output logic                     sram_cs_n,
  output logic                     mem_oe_n,
  output logic                     mem_we_n
);
  import card_pkg::*;

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  logic strap_taken, next_strap_taken;
  logic next_card_mode;

  // Samples the strap once after reset release and holds it.
  always_comb begin
    next_strap_taken = 1'b1;
    next_card_mode   = strap_taken ? card_mode : card_mode_strap;
  end

  // Registers the captured mode.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken <= 1'b0;
      card_mode   <= 1'b0;
    end else if (clk_en) begin
      strap_taken <= next_strap_taken;
      card_mode   <= next_card_mode;
    end
  end

  // ****************************************************************
  // Cycle decode
  // ****************************************************************
  logic [7:0]  card_config_reg_second [CCR_COUNT];
  logic [7:0]  next_ccr [CCR_COUNT];
  logic        served, next_served;
  logic        target_sram, next_target_sram;
  logic [15:0] next_data_out;
  logic [4:0]  next_core_reg_index;
  logic        io_enabled, ce_any, wide_req, lane_high;
  logic        attr_acc, attr_valid, common_acc, io_acc, cyc_active;
  logic        ccr_hit, flash_attr, flash_common, sram_common, io_sram;
  logic        mem_req, is_write, write_blocked, seq_start;
  logic        seq_busy, seq_done;
  logic [15:0] seq_rdata, seq_addr, seq_wdata, byte_addr;
  logic        seq_rd, seq_wr;
  logic [1:0]  ccr_index;
  logic [7:0]  ccr_rd_value;

  // Enable needs a nonzero index and no soft reset pending.
  assign io_enabled = (card_config_reg_second[0][CFG_INDEX_MSB:0] != CFG_INDEX_NONE) &&
                      !card_config_reg_second[0][SOFT_RESET_BIT];

  // Splits a card cycle into attribute, common and I/O kinds.
  assign ce_any     = card_mode && (!ce1_n || !ce2_n);
  assign wide_req   = !ce1_n && !ce2_n;
  assign lane_high  = ce1_n;
  assign attr_acc   = ce_any && !reg_n && (!oe_n || !we_n);
  assign common_acc = ce_any && reg_n && (!oe_n || !we_n);
  assign io_acc     = ce_any && io_enabled &&
                      (!iord_n || !iowr_n);
  assign cyc_active = attr_acc || common_acc || io_acc;
  assign attr_valid = attr_acc && !addr[0] && !ce1_n;
  assign ccr_hit    = attr_valid &&
                      (addr[15:3] == CCR_FIRST_ADDR[15:3]);
  assign ccr_index  = addr[2:1];
  assign flash_attr = attr_valid && !ccr_hit;
  assign flash_common = common_acc && shared_memory_match;
  assign sram_common  = common_acc && !shared_memory_match &&
                        !pio_select;
  assign io_sram    = io_acc && pio_select &&
                      (addr[4:0] == SRAM_DATA_PORT_INDEX);
  assign is_write   = !we_n || !iowr_n;
  assign write_blocked = (flash_attr || flash_common) && is_write &&
                         !nonvolatile_write_enable;
  assign mem_req    = flash_attr || flash_common || sram_common || io_sram;
  assign seq_start  = mem_req && !write_blocked && !served && !seq_busy;

  // Attribute space is byte wide; narrow cycles pick the byte by enables.
  assign byte_addr  = {addr[15:1], addr[0] | ce1_n};
  assign seq_addr   = io_sram ? sram_pointer : byte_addr;
  assign seq_wdata  = (wide_req && !attr_acc) ? data_in :
                      (lane_high ? {8'h00, data_in[15:8]} :
                                   {8'h00, data_in[7:0]});

  // Reads back a configuration register; interrupt bit shows the core.
  always_comb begin
    ccr_rd_value = card_config_reg_second[ccr_index];
    if (ccr_index == CCR_SECOND_ADDR[2:1]) begin
      ccr_rd_value[INTR_BIT] = core_irq;
    end
  end

  // Computes register writes, the served flag and the read data.
  always_comb begin
    for (int i = 0; i < CCR_COUNT; i++) begin
      next_ccr[i] = card_config_reg_second[i];
    end
    next_served         = served;
    next_target_sram    = target_sram;
    next_data_out       = data_out;
    next_core_reg_index = core_reg_index;
    if (!cyc_active) begin
      next_served = 1'b0;
    end else if (ccr_hit && !we_n && !served) begin
      next_ccr[ccr_index] = data_in[7:0];
      next_served         = 1'b1;
    end else if (write_blocked && !served) begin
      next_served = 1'b1;
    end else if (seq_done) begin
      next_served = 1'b1;
    end
    if (seq_start) begin
      next_target_sram = sram_common || io_sram;
    end
    if (ccr_hit && !oe_n) begin
      next_data_out = {8'h00, ccr_rd_value};
    end else if (seq_done) begin
      if (wide_req && !attr_acc) begin
        next_data_out = seq_rdata;
      end else if (lane_high) begin
        next_data_out = {seq_rdata[7:0], 8'h00};
      end else begin
        next_data_out = {8'h00, seq_rdata[7:0]};
      end
    end else if (io_acc && !iord_n && !io_sram) begin
      next_data_out = core_rdata;
    end
    if (io_acc) begin
      next_core_reg_index = addr[IO_REG_BITS-1:0];
    end
  end

  // Registers decode state; configuration registers clear on reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CCR_COUNT; i++) begin
        card_config_reg_second[i] <= CCR_RESET;
      end
      served         <= 1'b0;
      target_sram    <= 1'b0;
      data_out       <= 16'h0000;
      core_reg_index <= 5'h00;
    end else if (clk_en) begin
      for (int i = 0; i < CCR_COUNT; i++) begin
        card_config_reg_second[i] <= next_ccr[i];
      end
      served         <= next_served;
      target_sram    <= next_target_sram;
      data_out       <= next_data_out;
      core_reg_index <= next_core_reg_index;
    end
  end

  // ****************************************************************
  // Local memory sequencing
  // ****************************************************************
  byte_pair_sequencer u_seq (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .start     (seq_start),
    .wide      (wide_req && !attr_acc),
    .write     (is_write),
    .base_addr (seq_addr),
    .wdata     (seq_wdata),
    .mem_rdata (mem_rdata),
    .busy      (seq_busy),
    .done      (seq_done),
    .rdata     (seq_rdata),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_rd    (seq_rd),
    .mem_wr    (seq_wr)
  );

  // Chip selects follow the latched target while a phase runs.
  assign flash_cs_n = !((seq_rd || seq_wr) && !target_sram);
  assign sram_cs_n  = !((seq_rd || seq_wr) && target_sram);
  assign mem_oe_n   = !seq_rd;
  assign mem_we_n   = !seq_wr;

  // ****************************************************************
  // Pin reuse and core side
  // ****************************************************************
  logic                wait_n, inpack_n, iois16_n;
  logic [IRQ_PINS-1:0] card_val, card_oe;

  // Holds the host off until a memory cycle has been served.
  assign wait_n   = !(mem_req && !write_blocked && !served);
  assign inpack_n = !(io_acc && !iord_n);
  assign iois16_n = !(ce_any && io_enabled);
  assign data_oe  = wait_n && ((ccr_hit && !oe_n) ||
                    ((flash_attr || flash_common || sram_common) && !oe_n) ||
                    (io_acc && !iord_n));

  // Shared ready and width pins: CMOS in card mode, open drain otherwise.
  assign ready_pin_out = card_mode ? wait_n : 1'b0;
  assign ready_pin_oe  = card_mode ? 1'b1 : !isa_channel_ready;
  assign width_pin_out = card_mode ? iois16_n : 1'b0;
  assign width_pin_oe  = card_mode ? 1'b1 : isa_io_width16;

  // Card-mode values of the interrupt pins; spare ones are left undriven.
  always_comb begin
    card_val              = '1;
    card_oe               = '0;
    card_val[PIN_SRAM_CS] = sram_cs_n;
    card_oe[PIN_SRAM_CS]  = 1'b1;
    card_val[PIN_INPACK]  = inpack_n;
    card_oe[PIN_INPACK]   = 1'b1;
    card_val[PIN_STSCHG]  = 1'b1;
    card_oe[PIN_STSCHG]   = 1'b1;
    card_val[PIN_IREQ]    = !core_irq;
    card_oe[PIN_IREQ]     = 1'b1;
  end

  // Selects per pin between card function and ISA interrupt drive.
  for (genvar g = 0; g < IRQ_PINS; g++) begin : g_irq_pin
    assign irq_pin_out[g] = card_mode ? card_val[g] : 1'b1;
    assign irq_pin_oe[g]  = card_mode ? card_oe[g] : isa_irq_drive[g];
  end

  // ISA meanings of the shared inputs are passed only in ISA mode.
  assign byte_high_enable_n = card_mode ? 1'b1 : ce2_n;
  assign address_enable_isa = card_mode ? 1'b0 : reg_n;
  assign isa_memr_n         = card_mode ? 1'b1 : oe_n;
  assign isa_memw_n         = card_mode ? 1'b1 : we_n;
  assign isa_ior_n          = card_mode ? 1'b1 : iord_n;
  assign isa_iow_n          = card_mode ? 1'b1 : iowr_n;
  assign boot_rom_match_n   = card_mode ? 1'b1 : ce1_n;
  assign core_sleep_n       = sleep_n;
  assign eeprom_optional    = card_mode;
  assign core_soft_reset    = card_config_reg_second[0][SOFT_RESET_BIT];
  assign core_io_rd         = io_acc && !iord_n && !io_sram;
  assign core_io_wr         = io_acc && !iowr_n && !io_sram;
  assign core_wdata         = data_in;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  strap_held_a: assert property (strap_taken && $past(strap_taken) |->
    card_mode == $past(card_mode)) else $error("card mode changed");
  isa_pass_a: assert property (!card_mode |->
    isa_ior_n == iord_n && !ready_pin_out) else $error("isa pin lost");
  io_gate_a: assert property (!io_enabled |->
    !core_io_rd && !core_io_wr && inpack_n) else $error("io while off");
  ccr_write_a: assert property (clk_en && ccr_hit && !we_n && !served &&
    ccr_index == 2'b00 |=> card_config_reg_second[0] == $past(data_in[7:0]))
    else $error("ccr write lost");
  odd_attr_a: assert property (attr_acc && addr[0] |->
    !seq_start && !ccr_hit) else $error("odd attribute decoded");
  flash_block_a: assert property (seq_start && is_write &&
    !(sram_common || io_sram) |-> nonvolatile_write_enable)
    else $error("flash write not gated");
  sram_route_a: assert property (clk_en && seq_start && sram_common |=>
    target_sram) else $error("sram not targeted");
  reg_index_a: assert property (clk_en && io_acc |=>
    core_reg_index == $past(addr[4:0])) else $error("reg index wrong");
  ccr_reset_a: assert property (@(posedge mclk) disable iff (1'b0)
    !rst_n |-> card_config_reg_second[0] == CCR_RESET && !io_enabled)
    else $error("ccr not cleared");

endmodule // pc_card_host_interface
`default_nettype wire

/* test/local_memory_model.sv */
// Behavioural flash and shared RAM on the local memory bus.
`timescale 1ns/1ps
`default_nettype none
module local_memory_model (
  input  wire logic        mclk,
  input  wire logic        flash_cs_n,
  input  wire logic        sram_cs_n,
  input  wire logic        mem_oe_n,
  input  wire logic [15:0] mem_addr,
  output logic [7:0]       mem_rdata
);
  initial mem_rdata = 8'h00;
  // A selected part answers with an address pattern; an idle bus toggles.
  always @(posedge mclk) begin
    if (!mem_oe_n && !flash_cs_n) mem_rdata <= mem_addr[7:0] ^ 8'hA5;
    else if (!mem_oe_n && !sram_cs_n) mem_rdata <= mem_addr[7:0] ^ 8'h3C;
    else mem_rdata <= ~mem_rdata;
  end
endmodule // local_memory_model
`default_nettype wire

/* test/pc_card_host_interface_tb_top.sv */
// Self-checking bench for the card host port.
`timescale 1ns/1ps
`default_nettype none
module pc_card_host_interface_tb_top;
  import card_pkg::*;
  logic mclk, rst_n, clk_en, card_mode_strap, sleep_n, boot_rom_pin_n;
  logic ce1_n, ce2_n, reg_n, we_n, oe_n, iord_n, iowr_n, core_irq;
  logic shared_memory_match, pio_select, nonvolatile_write_enable;
  logic isa_channel_ready, isa_io_width16, data_oe, card_mode, core_sleep_n;
  logic ready_pin_out, ready_pin_oe, width_pin_out, width_pin_oe;
  logic eeprom_optional, core_soft_reset, core_io_rd, core_io_wr;
  logic byte_high_enable_n, address_enable_isa, isa_memr_n, isa_memw_n;
  logic isa_ior_n, isa_iow_n, boot_rom_match_n, flash_cs_n, sram_cs_n;
  logic mem_oe_n, mem_we_n;
  logic [15:0] addr, data_in, core_rdata, sram_pointer, data_out, core_wdata;
  logic [15:0] mem_addr, a, rd_q;
  logic [7:0] isa_irq_drive, irq_pin_out, irq_pin_oe, mem_rdata, mem_wdata;
  logic [7:0] v, m;
  logic [4:0] core_reg_index;
  logic [31:0] seed;
  logic [3:0] seen;
  int err_total, checked, i;
  localparam logic [6:0] AW = 7'h27, AR = 7'h2B, CR = 7'h1B, CW = 7'h37;
  localparam logic [6:0] IR = 7'h3D;
  pc_card_host_interface dut_u (.*);
  local_memory_model mem_u (.*);
  // Xorshift source and expected memory byte.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] mb(input logic fl, input logic [15:0] x);
    return x[7:0] ^ (fl ? 8'hA5 : 8'h3C);
  endfunction
  task automatic chk(input logic ok, input string s);
    checked++;
    if (!ok) begin
      err_total++;
      $display("ERROR %0t %s", $time, s);
    end
  endtask
  // One host cycle held until the wait line is seen high, then released.
  task automatic cyc(input logic [6:0] s, input logic [15:0] x, d);
    {ce1_n, ce2_n, reg_n, we_n, oe_n, iord_n, iowr_n} = s;
    addr = x;
    data_in = d;
    seen = 4'h0;
    for (int k = 0; k < 20; k++) begin
      @(posedge mclk);
      #1;
      seen = seen | {!flash_cs_n, !sram_cs_n, !mem_we_n, data_oe};
      if (k > 0 && ready_pin_out === 1'b1) break;
    end
    rd_q = data_out;
    {ce1_n, ce2_n, reg_n, we_n, oe_n, iord_n, iowr_n} = 7'h7F;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #20000;
    chk(1'b0, "watchdog expired");
    end_of_test();
  end
  initial begin
    seed = 32'h44FD; err_total = 0; checked = 0; rst_n = 1'b0; clk_en = 1'b1;
    card_mode_strap = 1'b1; sleep_n = 1'b0; boot_rom_pin_n = 1'b1;
    {ce1_n, ce2_n, reg_n, we_n, oe_n, iord_n, iowr_n} = 7'h7B;
    addr = 16'h0000; data_in = 16'h0000; shared_memory_match = 1'b1;
    pio_select = 1'b0; nonvolatile_write_enable = 1'b0; core_irq = 1'b0;
    core_rdata = rnd(); sram_pointer = rnd(); isa_irq_drive = rnd();
    isa_channel_ready = 1'b1; isa_io_width16 = 1'b0;
    repeat (20) @(posedge mclk);
    #1;
    chk(isa_memr_n === 1'b0, "isa pass");
    {ce1_n, ce2_n, reg_n, we_n, oe_n, iord_n, iowr_n} = 7'h7F;
    rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(card_mode === 1'b1 && eeprom_optional === 1'b1, "mode");
    chk(core_sleep_n === 1'b0 && isa_memr_n === 1'b1, "sleep");
    chk(irq_pin_oe === 8'h1E && irq_pin_out[PIN_IREQ] === 1'b1, "pins");
    cyc(IR, rnd(), 16'h0000);
    chk(seen[0] === 1'b0, "io before config");
    cyc(AR, 16'h03F1, 16'h0000);
    chk(seen[0] === 1'b0, "odd attribute");
    cyc(AR, 16'h0000, 16'h0000);
    chk(seen[3] === 1'b1 && rd_q[7:0] === mb(1'b1, 16'h0000), "cis");
    for (i = 3; i >= 0; i--) begin
      v = (i == 0) ? 8'h21 : rnd();
      m = (i == 1) ? 8'hFD : 8'hFF;
      cyc(AW, CCR_FIRST_ADDR + 16'(2 * i), {8'h00, v});
      cyc(AR, CCR_FIRST_ADDR + 16'(2 * i), 16'h0000);
      chk((rd_q[7:0] & m) === (v & m), "ccr");
    end
    for (i = 0; i < 4; i++) begin
      a = rnd();
      core_rdata = rnd();
      cyc(IR, a, 16'h0000);
      chk(core_reg_index === a[4:0] && rd_q === core_rdata, "io");
    end
    for (i = 0; i < 2; i++) begin
      shared_memory_match = i[0];
      a = rnd();
      a[0] = 1'b0;
      cyc(CR, a, 16'h0000);
      chk(seen[3:2] === {i[0], !i[0]}, "steer");
      chk(rd_q === {mb(i[0], a + 16'h0001), mb(i[0], a)}, "wide");
    end
    for (i = 0; i < 2; i++) begin
      nonvolatile_write_enable = i[0];
      cyc(CW, 16'h0100, rnd());
      chk(seen[1] === i[0], "flash write");
    end
    pio_select = 1'b1;
    cyc(CR, 16'h0000, 16'h0000);
    chk(seen[3] === 1'b1 && rd_q[7:0] === mb(1'b1, 16'h0000), "pio flash");
    // Wide I/O read of the SRAM data port: two byte reads joined into one word.
    cyc(7'h1D, 16'h0010, 16'h0000);
    chk(seen[2] === 1'b1 && rd_q === {mb(1'b0, sram_pointer + 16'h0001), mb(1'b0, sram_pointer)}, "data port");
    end_of_test();
  end
endmodule // pc_card_host_interface_tb_top
`default_nettype wire
